// [include/seq_pkg.sv]
// Constants and carrier types for the codec output-path power sequencer.
package seq_pkg;
    // System clock and the documented times in their own units.
    localparam int CLK_HZ       = 10_000_000;
    localparam int SETTLE_MS    = 10;
    localparam int LINE_RAMP_MS = 300;
    localparam int PDN_LOW_NS   = 150;
    localparam int SETTLE_CYC_DEF = SETTLE_MS * (CLK_HZ / 1000);
    localparam int RAMP_CYC_DEF   = LINE_RAMP_MS * (CLK_HZ / 1000);
    localparam int PDN_CYC =
        (PDN_LOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int WAIT_W = 22;

    // Serial control port: last divider count of a 4-cycle half-bit, end phase of a 16-bit frame.
    localparam logic [1:0] SER_DIV_LAST = 2'h3;
    localparam logic [5:0] SER_PH_END   = 6'h20;

    // Software register map (word index on the Avalon address).
    localparam logic [2:0] A_CMD    = 3'h0;
    localparam logic [2:0] A_CFG    = 3'h1;
    localparam logic [2:0] A_VOL    = 3'h2;
    localparam logic [2:0] A_STATUS = 3'h3;

    // Commands written to A_CMD bits [2:0].
    localparam logic [2:0] C_WAKE       = 3'h0;
    localparam logic [2:0] C_MONO_START = 3'h1;
    localparam logic [2:0] C_MONO_STOP  = 3'h2;
    localparam logic [2:0] C_LINE_START = 3'h3;
    localparam logic [2:0] C_LINE_STOP  = 3'h4;
    localparam logic [2:0] C_CLK_STOP   = 3'h5;
    localparam logic [2:0] C_SHUTDOWN   = 3'h6;
    localparam logic [2:0] C_HARD_DOWN  = 3'h7;

    // Clock modes held in A_CFG bits [5:4].
    localparam logic [1:0] M_PLL_MASTER = 2'h0;
    localparam logic [1:0] M_PLL_SLAVE  = 2'h1;
    localparam logic [1:0] M_PLL_MCLK   = 2'h2;

    // Shadow copies of device registers and their device addresses.
    localparam logic [2:0] R_PM1 = 3'h0;
    localparam logic [2:0] R_PM2 = 3'h1;
    localparam logic [2:0] R_SEL1 = 3'h2;
    localparam logic [2:0] R_SEL2 = 3'h3;
    localparam logic [2:0] R_MODE = 3'h4;
    localparam logic [2:0] R_VOL = 3'h5;
    localparam logic [5:0][7:0] DEV_ADDR =
        {8'h0A, 8'h05, 8'h03, 8'h02, 8'h01, 8'h00};
    localparam logic [5:0][7:0] DEV_DEFAULT =
        {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    // Bit positions inside the device registers.
    localparam int B_DAC_POWER   = 2;
    localparam int B_LINE_AMP    = 3;
    localparam int B_SPK_AMP     = 4;
    localparam int B_MONO_AMP    = 5;
    localparam int B_MIDRAIL_REF = 6;
    localparam int B_PLL_POWER   = 0;
    localparam int B_CLK_OUT_EN  = 1;
    localparam int B_DAC_TO_SPK  = 0;
    localparam int B_MONO_TO_SPK = 5;
    localparam int B_SPK_RELEASE = 7;
    localparam int B_DAC_TO_LINE = 4;
    localparam int B_LINE_SAVE   = 6;

    // Sequencer step operations.
    localparam logic [2:0] OP_END  = 3'h0;
    localparam logic [2:0] OP_SET  = 3'h1;
    localparam logic [2:0] OP_CLR  = 3'h2;
    localparam logic [2:0] OP_LOAD = 3'h3;
    localparam logic [2:0] OP_WAIT = 3'h4;
    localparam logic [2:0] OP_CLKS = 3'h5;
    localparam logic [2:0] OP_PDN  = 3'h6;
    localparam logic [7:0] W_SETTLE = 8'h00;
    localparam logic [7:0] W_RAMP   = 8'h01;
    localparam logic [7:0] W_PDN    = 8'h02;

    typedef struct packed {
        logic [2:0] op;
        logic [2:0] idx;
        logic [7:0] val;
    } step_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } frame_s;
endpackage

// [verilog/output_path_sequencer.sv]
// Host-side power sequencer driving the codec over its serial control port.
`timescale 1ns/1ns
module output_path_sequencer
    import seq_pkg::*;
#(
    parameter int SETTLE_CYC = SETTLE_CYC_DEF,
    parameter int RAMP_CYC   = RAMP_CYC_DEF
) (
    input  wire logic        CLK_SYS,
    input  wire logic        SRST,
    input  wire logic [2:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    output logic             CODEC_CS_N,
    output logic             CODEC_CCLK,
    output logic             CODEC_CDATA,
    output logic             POWER_DOWN_PIN_N,
    output logic             MASTER_CLOCK_RUN,
    output logic             SERIAL_CLOCK_RUN
);
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_EXEC = 4'b0010,
        S_SEND = 4'b0100,
        S_WAIT = 4'b1000
    } state_e;

    state_e            state_r;
    logic [2:0]        cmd_r;
    logic [3:0]        step_r;
    logic [3:0]        rate_r;
    logic [1:0]        mode_r;
    logic [7:0]        vol_r;
    logic              refused_r;
    logic [5:0][7:0]   shadow_r;
    logic [WAIT_W-1:0] wait_r;
    logic              rd_done_r;
    logic [31:0]       rdata_r;
    logic [15:0]       sh_r;
    logic [5:0]        ph_r;
    logic [1:0]        div_r;
    logic              ser_busy_r;
    logic              settle_seen_r;
    logic              ramp_seen_r;

    // Step table: one entry per register write, wait or pin change.
    function automatic step_s step_f(input logic [2:0] c,
                                     input logic [1:0] m,
                                     input logic [3:0] i);
        step_s s;
        s = '{OP_END, R_PM1, 8'h00};
        case ({c, i})
            {C_WAKE, 4'h0}: s = '{OP_PDN, R_PM1, 8'h00};
            {C_WAKE, 4'h1}: s = '{OP_WAIT, R_PM1, W_PDN};
            {C_WAKE, 4'h2}: s = '{OP_PDN, R_PM1, 8'h01};
            {C_WAKE, 4'h3}: s = '{OP_CLKS, R_PM1, 8'h03};
            {C_WAKE, 4'h4}: s = '{OP_SET, R_PM1, 8'(1 << B_MIDRAIL_REF)};
            // PLL modes power the PLL once the reference is up
            {C_WAKE, 4'h5}:
                s = (m == M_PLL_MASTER) ?
                    step_s'{OP_SET, R_PM2,
                        8'((1 << B_PLL_POWER) | (1 << B_CLK_OUT_EN))} :
                    (m == M_PLL_SLAVE) ?
                    step_s'{OP_SET, R_PM2, 8'(1 << B_PLL_POWER)} :
                    step_s'{OP_END, R_PM1, 8'h00};
            {C_MONO_START, 4'h0}: s = '{OP_SET, R_PM1,
                8'((1 << B_MONO_AMP) | (1 << B_SPK_AMP))};
            {C_MONO_START, 4'h1}: s = '{OP_CLR, R_SEL1,
                8'(1 << B_DAC_TO_SPK)};
            {C_MONO_START, 4'h2}: s = '{OP_SET, R_SEL1,
                8'(1 << B_MONO_TO_SPK)};
            {C_MONO_START, 4'h3}: s = '{OP_WAIT, R_PM1, W_SETTLE};
            {C_MONO_START, 4'h4}: s = '{OP_SET, R_SEL1,
                8'(1 << B_SPK_RELEASE)};
            {C_MONO_STOP, 4'h0}: s = '{OP_CLR, R_SEL1,
                8'(1 << B_SPK_RELEASE)};
            {C_MONO_STOP, 4'h1}: s = '{OP_CLR, R_PM1,
                8'((1 << B_MONO_AMP) | (1 << B_SPK_AMP))};
            {C_MONO_STOP, 4'h2}: s = '{OP_CLR, R_SEL1,
                8'(1 << B_MONO_TO_SPK)};
            {C_LINE_START, 4'h0}: s = '{OP_LOAD, R_MODE, 8'h00};
            {C_LINE_START, 4'h1}: s = '{OP_SET, R_SEL2,
                8'(1 << B_DAC_TO_LINE)};
            {C_LINE_START, 4'h2}: s = '{OP_LOAD, R_VOL, 8'h00};
            {C_LINE_START, 4'h3}: s = '{OP_SET, R_SEL2,
                8'(1 << B_LINE_SAVE)};
            {C_LINE_START, 4'h4}: s = '{OP_SET, R_PM1, 8'((1 << B_DAC_POWER)
                | (1 << B_MONO_AMP) | (1 << B_LINE_AMP))};
            {C_LINE_START, 4'h5}: s = '{OP_WAIT, R_PM1, W_RAMP};
            {C_LINE_START, 4'h6}: s = '{OP_CLR, R_SEL2,
                8'(1 << B_LINE_SAVE)};
            {C_LINE_STOP, 4'h0}: s = '{OP_SET, R_SEL2, 8'(1 << B_LINE_SAVE)};
            {C_LINE_STOP, 4'h1}: s = '{OP_CLR, R_PM1, 8'((1 << B_DAC_POWER)
                | (1 << B_MONO_AMP) | (1 << B_LINE_AMP))};
            {C_LINE_STOP, 4'h2}: s = '{OP_CLR, R_SEL2,
                8'(1 << B_DAC_TO_LINE)};
            {C_LINE_STOP, 4'h3}: s = '{OP_WAIT, R_PM1, W_RAMP};
            {C_LINE_STOP, 4'h4}: s = '{OP_CLR, R_SEL2, 8'(1 << B_LINE_SAVE)};
            // PLL off, clock out off, then clocks
            {C_CLK_STOP, 4'h0}, {C_SHUTDOWN, 4'h1}:
                s = (m == M_PLL_MASTER || m == M_PLL_SLAVE) ?
                    step_s'{OP_CLR, R_PM2, 8'(1 << B_PLL_POWER)} :
                    step_s'{OP_CLKS, R_PM1, 8'h00};
            // slave mode skips the clock output write
            {C_CLK_STOP, 4'h1}, {C_SHUTDOWN, 4'h2}:
                s = (m == M_PLL_MASTER) ?
                    step_s'{OP_CLR, R_PM2, 8'(1 << B_CLK_OUT_EN)} :
                    step_s'{OP_CLKS, R_PM1, 8'h00};
            // master-clock slave stops clocks without writes
            {C_CLK_STOP, 4'h2}, {C_SHUTDOWN, 4'h3}:
                s = '{OP_CLKS, R_PM1, 8'h00};
            // all blocks but the reference, clocks, then reference
            {C_SHUTDOWN, 4'h0}: s = '{OP_CLR, R_PM1,
                8'(~(1 << B_MIDRAIL_REF))};
            {C_SHUTDOWN, 4'h4}: s = '{OP_CLR, R_PM1, 8'(1 << B_MIDRAIL_REF)};
            {C_HARD_DOWN, 4'h0}: s = '{OP_CLKS, R_PM1, 8'h00};
            {C_HARD_DOWN, 4'h1}: s = '{OP_PDN, R_PM1, 8'h00};
            default: s = '{OP_END, R_PM1, 8'h00};
        endcase
        return s;
    endfunction

    step_s      cur;
    logic [7:0] old_byte;
    logic [7:0] new_byte;
    logic [7:0] load_byte;
    logic       cmd_wr;
    logic       cmd_take;
    logic       refuse;
    logic       rd_take;
    logic       ser_tick;
    logic       ser_start;
    logic       dac_on;
    logic [WAIT_W-1:0] wait_load;
    logic [31:0] status_word;
    logic [31:0] rd_mux;

    assign cur       = step_f(cmd_r, mode_r, step_r);
    assign old_byte  = shadow_r[cur.idx];
    assign load_byte = (cur.idx == R_VOL) ? vol_r : {4'h0, rate_r};
    assign new_byte  = (cur.op == OP_SET) ? (old_byte | cur.val) :
                       (cur.op == OP_CLR) ? (old_byte & ~cur.val) :
                       load_byte;
    assign ser_start = (state_r == S_EXEC) &&
                       (cur.op == OP_SET || cur.op == OP_CLR ||
                        cur.op == OP_LOAD);
    assign dac_on    = shadow_r[R_PM1][B_DAC_POWER];
    assign wait_load = (cur.val == W_SETTLE) ? WAIT_W'(SETTLE_CYC - 1) :
                       (cur.val == W_RAMP)   ? WAIT_W'(RAMP_CYC - 1) :
                       WAIT_W'(PDN_CYC - 1);

    // Command writes stall on waitrequest while a sequence is running.
    assign cmd_wr   = AVS_WRITE && AVS_ADDRESS == A_CMD;
    assign cmd_take = cmd_wr && state_r == S_IDLE;
    // refuse clock stop while the DAC is in use
    assign refuse   = cmd_take && AVS_WRITEDATA[2:0] == C_CLK_STOP && dac_on;
    assign rd_take  = AVS_READ && !rd_done_r;
    assign AVS_WAITREQUEST = rd_take || (cmd_wr && state_r != S_IDLE);
    assign AVS_READDATA = rdata_r;
    assign status_word = {16'h0000, 1'b0, cmd_r, step_r, 2'h0,
                          SERIAL_CLOCK_RUN, MASTER_CLOCK_RUN,
                          POWER_DOWN_PIN_N, refused_r,
                          ser_busy_r, state_r != S_IDLE};
    assign rd_mux = (AVS_ADDRESS == A_CFG) ? {26'h0, mode_r, rate_r} :
                    (AVS_ADDRESS == A_VOL) ? {24'h0, vol_r} :
                    (AVS_ADDRESS == A_STATUS) ? status_word : 32'h0000_0000;

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            rd_done_r <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rate_r    <= 4'h0;
            mode_r    <= M_PLL_MASTER;
            vol_r     <= 8'h00;
        end else begin
            rd_done_r <= rd_take;
            if (rd_take) rdata_r <= rd_mux;
            if (AVS_WRITE && AVS_ADDRESS == A_CFG) begin
                rate_r <= AVS_WRITEDATA[3:0];
                mode_r <= AVS_WRITEDATA[5:4];
            end
            if (AVS_WRITE && AVS_ADDRESS == A_VOL) vol_r <= AVS_WRITEDATA[7:0];
        end
    end

    // Sequencer.
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            state_r          <= S_IDLE;
            cmd_r            <= C_WAKE;
            step_r           <= 4'h0;
            wait_r           <= '0;
            refused_r        <= 1'b0;
            POWER_DOWN_PIN_N <= 1'b0;
            MASTER_CLOCK_RUN <= 1'b0;
            SERIAL_CLOCK_RUN <= 1'b0;
        end else begin
            case (state_r)
                S_IDLE: begin
                    if (cmd_take) begin
                        cmd_r     <= AVS_WRITEDATA[2:0];
                        step_r    <= 4'h0;
                        refused_r <= refuse;
                        state_r   <= refuse ? S_IDLE : S_EXEC;
                    end
                end
                S_EXEC: begin
                    case (cur.op)
                        OP_SET, OP_CLR, OP_LOAD: state_r <= S_SEND;
                        OP_WAIT: begin
                            wait_r  <= wait_load;
                            state_r <= S_WAIT;
                        end
                        OP_CLKS: begin
                            MASTER_CLOCK_RUN <= cur.val[1];
                            SERIAL_CLOCK_RUN <= cur.val[0];
                            step_r <= step_r + 4'h1;
                        end
                        OP_PDN: begin
                            POWER_DOWN_PIN_N <= cur.val[0];
                            step_r <= step_r + 4'h1;
                        end
                        default: state_r <= S_IDLE;
                    endcase
                end
                S_SEND: begin
                    if (!ser_busy_r) begin
                        step_r  <= step_r + 4'h1;
                        state_r <= S_EXEC;
                    end
                end
                S_WAIT: begin
                    if (wait_r == '0) begin
                        step_r  <= step_r + 4'h1;
                        state_r <= S_EXEC;
                    end else begin
                        wait_r <= wait_r - WAIT_W'(1);
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // The shadow follows every frame sent, so SET and CLR keep other bits.
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            shadow_r <= DEV_DEFAULT;
        // device registers reset while the pin is low
        end else if (!POWER_DOWN_PIN_N) begin
            shadow_r <= DEV_DEFAULT;
        end else if (ser_start) begin
            shadow_r[cur.idx] <= new_byte;
        end
    end

    // Serial writer: data changes with the clock low, device samples rising.
    assign ser_tick = ser_busy_r && div_r == SER_DIV_LAST;
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            ser_busy_r  <= 1'b0;
            sh_r        <= 16'h0000;
            ph_r        <= 6'h00;
            div_r       <= 2'h0;
            CODEC_CS_N  <= 1'b1;
            CODEC_CCLK  <= 1'b1;
            CODEC_CDATA <= 1'b0;
        end else if (ser_start) begin
            ser_busy_r <= 1'b1;
            sh_r       <= frame_s'{DEV_ADDR[cur.idx], new_byte};
            ph_r       <= 6'h00;
            div_r      <= 2'h0;
            CODEC_CS_N <= 1'b0;
        end else if (ser_busy_r) begin
            div_r <= div_r + 2'h1;
            if (ser_tick) begin
                ph_r <= ph_r + 6'h01;
                if (ph_r == SER_PH_END) begin
                    ser_busy_r <= 1'b0;
                    CODEC_CS_N <= 1'b1;
                end else if (!ph_r[0]) begin
                    CODEC_CCLK  <= 1'b0;
                    CODEC_CDATA <= sh_r[15];
                end else begin
                    CODEC_CCLK <= 1'b1;
                    sh_r       <= {sh_r[14:0], 1'b0};
                end
            end
        end
    end

    // Helper flags for the checks: set when a settle or ramp wait expires, cleared
    // on a new command.
    always_ff @(posedge CLK_SYS) begin
        if (SRST || cmd_take) begin
            settle_seen_r <= 1'b0;
            ramp_seen_r   <= 1'b0;
        end else if (state_r == S_WAIT && wait_r == '0) begin
            settle_seen_r <= settle_seen_r || cur.val == W_SETTLE;
            ramp_seen_r   <= ramp_seen_r || cur.val == W_RAMP;
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);

    a_mono_route_order: assert property (
        $rose(shadow_r[R_SEL1][B_MONO_TO_SPK]) |->
        shadow_r[R_PM1][B_MONO_AMP] && shadow_r[R_PM1][B_SPK_AMP] &&
        !shadow_r[R_SEL1][B_DAC_TO_SPK])
        else $error("mono route set before amps or with DAC route");
    a_release_settled: assert property (
        $rose(shadow_r[R_SEL1][B_SPK_RELEASE]) |-> settle_seen_r)
        else $error("speaker released before mono input settled");
    a_mono_stop_order: assert property (
        $fell(shadow_r[R_PM1][B_SPK_AMP]) |->
        !shadow_r[R_SEL1][B_SPK_RELEASE])
        else $error("speaker amp powered down while released");
    a_line_power_ready: assert property (
        $rose(shadow_r[R_PM1][B_LINE_AMP]) |->
        shadow_r[R_SEL2][B_LINE_SAVE] && shadow_r[R_SEL2][B_DAC_TO_LINE])
        else $error("line amp powered before save mode and route");
    a_line_save_exit: assert property (
        $fell(shadow_r[R_SEL2][B_LINE_SAVE]) |-> ramp_seen_r)
        else $error("line save mode left before outputs settled");
    a_line_stop_save: assert property (
        $fell(shadow_r[R_PM1][B_LINE_AMP]) |-> shadow_r[R_SEL2][B_LINE_SAVE])
        else $error("line amp powered down outside save mode");
    a_clock_stop_idle: assert property (
        $fell(MASTER_CLOCK_RUN) && POWER_DOWN_PIN_N |-> !dac_on)
        else $error("master clock stopped while the DAC is on");
    a_pll_before_clk: assert property (
        $fell(SERIAL_CLOCK_RUN) && POWER_DOWN_PIN_N &&
        mode_r != M_PLL_MCLK |-> !shadow_r[R_PM2][B_PLL_POWER])
        else $error("clocks stopped with the PLL still powered");
    a_ref_drop_last: assert property (
        $fell(shadow_r[R_PM1][B_MIDRAIL_REF]) && POWER_DOWN_PIN_N |->
        shadow_r[R_PM1] == 8'h00 && !MASTER_CLOCK_RUN)
        else $error("reference dropped before blocks and clocks");
    a_pin_reset: assert property (
        !POWER_DOWN_PIN_N |=> shadow_r == DEV_DEFAULT)
        else $error("shadow not at defaults during power-down");
    a_frame_hold: assert property (
        $fell(CODEC_CS_N) |-> !CODEC_CS_N [*8])
        else $error("serial frame shorter than expected");

    c_mono_start: cover property (
        cmd_r == C_MONO_START && $rose(shadow_r[R_SEL1][B_SPK_RELEASE]));
    c_line_start: cover property (
        cmd_r == C_LINE_START && $fell(shadow_r[R_SEL2][B_LINE_SAVE]));
    c_clock_stop: cover property (cmd_r == C_CLK_STOP && $fell(SERIAL_CLOCK_RUN));
    c_refused: cover property ($rose(refused_r));
endmodule // output_path_sequencer

// [dv/codec_model.sv]
// Codec register file seen through its serial control port.
`timescale 1ns/1ns
module codec_model (
    input wire logic clk,
    input wire logic cs_n,
    input wire logic cclk,
    input wire logic cdata,
    input wire logic pin_n,
    input wire logic mrun
);
    logic [7:0]  regs [16];
    logic [15:0] sr;
    logic [16:0] log_f [64];
    int          log_t [64];
    int          cnt = 0;
    int          n   = 0;
    int          cyc = 0;
    int          bad = 0;

    always @(posedge clk) begin
        cyc++;
        if (!pin_n) foreach (regs[i]) regs[i] = 8'h00;
    end
    always @(negedge cs_n) cnt = 0;
    always @(posedge cclk) if (!cs_n) begin
        sr = {sr[14:0], cdata};
        cnt++;
    end
    // volume and DAC output timing are not modelled.
    // reference drops only with clocks stopped
    always @(posedge cs_n) if (cnt == 16) begin
        if (sr[15:8] == 8'h00 && !sr[6] && mrun) bad++;
        regs[sr[11:8]] = sr[7:0];
        log_f[n] = {mrun, sr};
        log_t[n] = cyc;
        n++;
    end
    // clocks stop only with DAC and PLL down
    always @(negedge mrun) if (regs[0][2] || regs[1][0]) bad++;
endmodule // codec_model

// [dv/output_path_sequencer_test.sv]
// Self-checking bench for the output-path power sequencer.
`timescale 1ns/1ns
module output_path_sequencer_test import seq_pkg::*;;
    localparam int SETTLE = 20;
    localparam int RAMP   = 30;
    logic        clk_sys = 1'b0;
    logic        srst    = 1'b1;
    logic [2:0]  adr     = 3'h0;
    logic        rd      = 1'b0;
    logic        wr      = 1'b0;
    logic [31:0] wdata   = 32'h0000_0000;
    logic [31:0] rdata;
    logic [31:0] v;
    logic        waitreq, cs_n, cclk, cdata, pin_n, mrun, srun;
    int          err_total = 0;
    int          cmp_count = 0;
    int          p = 0;

    always #50 clk_sys = ~clk_sys;

    output_path_sequencer #(.SETTLE_CYC(SETTLE), .RAMP_CYC(RAMP)) dut_u (
        .CLK_SYS(clk_sys), .SRST(srst), .AVS_ADDRESS(adr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(waitreq), .CODEC_CS_N(cs_n), .CODEC_CCLK(cclk),
        .CODEC_CDATA(cdata), .POWER_DOWN_PIN_N(pin_n),
        .MASTER_CLOCK_RUN(mrun), .SERIAL_CLOCK_RUN(srun));
    codec_model model_u (.clk(clk_sys), .cs_n(cs_n), .cclk(cclk),
        .cdata(cdata), .pin_n(pin_n), .mrun(mrun));

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim;
        if (err_total == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // One Avalon access; read data lands in v.
    task automatic bus(input logic w, input logic [2:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_sys);
        adr <= a;
        rd <= !w;
        wr <= w;
        wdata <= d;
        do begin
            @(posedge clk_sys);
            k++;
        end while (waitreq !== 1'b0 && k < 5000);
        if (k >= 5000) begin
            err_total++;
            end_sim;
        end
        v = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic cmd(input logic [2:0] c);
        int k;
        k = 0;
        bus(1'b1, A_CMD, {29'h0, c});
        do begin
            bus(1'b0, A_STATUS, 32'h0);
            k++;
        end while (v[0] !== 1'b0 && k < 3000);
        if (v[0] !== 1'b0) begin
            err_total++;
            end_sim;
        end
    endtask

    // Next logged frame, clock state at that frame and minimum spacing.
    task automatic fr(input logic c, input logic [15:0] f, input int gap);
        chk("frame", {15'h0, model_u.log_f[p]}, {15'h0, c, f});
        if (gap > 0)
            chk("gap", {31'h0, model_u.log_t[p] - model_u.log_t[p-1] >= gap},
                32'h1);
        p++;
    endtask

    initial begin
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        bus(1'b0, A_STATUS, 32'h0);
        chk("status", v[5:3], 3'h0);
        bus(1'b1, A_CFG, 32'h0000_0025);
        bus(1'b1, A_VOL, 32'h0000_0030);
        bus(1'b1, 3'h6, 32'h0000_00FF);
        bus(1'b0, 3'h7, 32'h0);
        chk("unmapped", v, 32'h0000_0000);
        bus(1'b0, A_CFG, 32'h0);
        chk("cfg", v, 32'h0000_0025);
        bus(1'b0, A_VOL, 32'h0);
        chk("vol", v, 32'h0000_0030);
        cmd(C_WAKE);
        fr(1'b1, 16'h0040, 0);
        cmd(C_MONO_START);
        fr(1'b1, 16'h0070, 0);
        fr(1'b1, 16'h0200, 0);
        fr(1'b1, 16'h0220, 0);
        fr(1'b1, 16'h02A0, SETTLE + 130);
        cmd(C_CLK_STOP);
        bus(1'b0, A_STATUS, 32'h0);
        chk("mono clocks", v[5:2], 4'h2);
        cmd(C_MONO_STOP);
        fr(1'b0, 16'h0220, 0);
        fr(1'b0, 16'h0040, 0);
        fr(1'b0, 16'h0200, 0);
        cmd(C_WAKE);
        fr(1'b1, 16'h0040, 0);
        cmd(C_LINE_START);
        fr(1'b1, 16'h0505, 0);
        fr(1'b1, 16'h0310, 0);
        fr(1'b1, 16'h0A30, 0);
        fr(1'b1, 16'h0350, 0);
        fr(1'b1, 16'h006C, 0);
        fr(1'b1, 16'h0310, RAMP + 130);
        cmd(C_CLK_STOP);
        bus(1'b0, A_STATUS, 32'h0);
        chk("refused", v[5:2], 4'hF);
        chk("last cmd", v[14:12], C_CLK_STOP);
        cmd(C_LINE_STOP);
        fr(1'b1, 16'h0350, 0);
        fr(1'b1, 16'h0040, 0);
        fr(1'b1, 16'h0340, 0);
        fr(1'b1, 16'h0300, RAMP + 130);
        for (int m = 0; m < 3; m++) begin
            bus(1'b1, A_CFG, {26'h0, m[1:0], 4'h5});
            cmd(C_WAKE);
            fr(1'b1, 16'h0040, 0);
            if (m == 0) fr(1'b1, 16'h0103, 0);
            if (m == 1) fr(1'b1, 16'h0101, 0);
            cmd(C_CLK_STOP);
            if (m == 0) fr(1'b1, 16'h0102, 0);
            if (m < 2) fr(1'b1, 16'h0100, 0);
            bus(1'b0, A_STATUS, 32'h0);
            chk("stopped", v[5:4], 2'h0);
        end
        cmd(C_WAKE);
        fr(1'b1, 16'h0040, 0);
        cmd(C_SHUTDOWN);
        fr(1'b1, 16'h0040, 0);
        fr(1'b0, 16'h0000, 0);
        chk("order", model_u.bad, 0);
        cmd(C_WAKE);
        fr(1'b1, 16'h0040, 0);
        cmd(C_HARD_DOWN);
        bus(1'b0, A_STATUS, 32'h0);
        chk("hard down", v[5:3], 3'h0);
        chk("cleared", {24'h0, model_u.regs[0]}, 32'h0);
        chk("frames", model_u.n, p);
        end_sim;
    end

    initial begin
        repeat (60000) @(posedge clk_sys);
        err_total++;
        end_sim;
    end
endmodule // output_path_sequencer_test
